// ### rtl/smni_input_status.v
// Network input data map: two status words and four 32-bit value slots.
// Assumes the host command word and configuration arrive on this clock; pins are synchronised here.
`timescale 1ns/10ps
`default_nettype none
`include "smni_consts.vh"
module smni_input_status #(
  parameter [31:0] HEARTBEAT_CYCLES = `SMNI_HEARTBEAT_CYCLES
) (
  input wire clk,
  input wire srst,
  input wire [15:0] commandWord,
  input wire [15:0] reservedMask,
  input wire [1:0] inputPin,
  input wire [3:0] chOneInputFunction,
  input wire [3:0] chTwoInputFunction,
  input wire [3:0] chOneValueSelect,
  input wire [3:0] chTwoValueSelect,
  input wire [1:0] swapWords,
  input wire memoryError,
  input wire [7:0] chOneErrorBits,
  input wire [7:0] chTwoErrorBits,
  input wire [31:0] chOneDataValue,
  input wire [31:0] chTwoDataValue,
  input wire [31:0] chOneActualValue,
  input wire [31:0] chTwoActualValue,
  input wire [31:0] chOneVelocity,
  input wire [31:0] chTwoVelocity,
  input wire [3:0] wordAddr,
  output reg [15:0] wordData,
  output reg programStrobe,
  output reg [15:0] chOneStatus_reg,
  output reg [15:0] chTwoStatus_reg
);
  ////////////////////////////////////////////////////////////////////////////////
  // Input pin synchronisers.
  reg [1:0] pinMeta_reg;
  reg [1:0] pinSync_reg;
  always @(posedge clk) begin
    if (srst) begin
      pinMeta_reg <= 2'h0;
      pinSync_reg <= 2'h0;
    end else begin
      pinMeta_reg <= inputPin;
      pinSync_reg <= pinMeta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit handshake and command error.
  reg transmitPrev_reg;
  reg ack_reg;
  reg cmdErrOne_reg;
  reg cmdErrTwo_reg;
  wire transmit = commandWord[`SMNI_CMD_TRANSMIT];
  wire transmitRise = transmit & ~transmitPrev_reg;
  wire reservedSet = |(commandWord & reservedMask);
  wire noCommand = ~|commandWord[`SMNI_CMD_TRANSMIT-1:0];
  always @(posedge clk) begin
    if (srst) begin
      transmitPrev_reg <= 1'b0;
      ack_reg <= 1'b0;
      cmdErrOne_reg <= 1'b0;
      cmdErrTwo_reg <= 1'b0;
      programStrobe <= 1'b0;
    end else begin
      transmitPrev_reg <= transmit;
      if (!transmit) begin
        ack_reg <= 1'b0;
      end else if (transmitRise) begin
        ack_reg <= 1'b1;
      end
      if (transmitRise) begin
        cmdErrOne_reg <= reservedSet;
        cmdErrTwo_reg <= reservedSet;
      end
      // Parameters are only programmed when some command bit rides the edge.
      programStrobe <= transmitRise & ~noCommand & ~reservedSet;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Heartbeat and capture channels.
  wire beat;
  smni_heartbeat #(
    .HALF_PERIOD(HEARTBEAT_CYCLES)
  ) uHeartbeat (
    .clk(clk),
    .srst(srst),
    .beat(beat)
  );

  wire [1:0] capFlag;
  wire [1:0] inState;
  wire [63:0] capValue;
  wire [7:0] inFunc = {chTwoInputFunction, chOneInputFunction};
  wire [63:0] dataVals = {chTwoDataValue, chOneDataValue};
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gChannel
      smni_capture_channel uCapture (
        .clk(clk),
        .srst(srst),
        .inputSync(pinSync_reg[ch]),
        .inputFunction(inFunc[ch*4 +: 4]),
        .dataValue(dataVals[ch*32 +: 32]),
        .clearCaptured(transmitRise),
        .capturedFlag(capFlag[ch]),
        .capturedValue(capValue[ch*32 +: 32]),
        .inputState(inState[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Value slot selection.
  reg [31:0] oneFirst;
  reg [31:0] oneSecond;
  reg [31:0] twoFirst;
  reg [31:0] twoSecond;
  always @* begin
    case (chOneValueSelect)
      4'h1: begin
        oneFirst = chOneDataValue;
        oneSecond = chOneVelocity;
      end
      4'h2: begin
        oneFirst = chOneVelocity;
        oneSecond = chOneActualValue;
      end
      `SMNI_SEL_DATA_CAP: begin
        oneFirst = chOneDataValue;
        oneSecond = capValue[31:0];
      end
      `SMNI_SEL_VEL_CAP: begin
        oneFirst = chOneVelocity;
        oneSecond = capValue[31:0];
      end
      default: begin
        oneFirst = chOneDataValue;
        oneSecond = chOneActualValue;
      end
    endcase
    case (chTwoValueSelect)
      4'h1: begin
        twoFirst = chTwoDataValue;
        twoSecond = chTwoVelocity;
      end
      4'h2: begin
        twoFirst = chTwoVelocity;
        twoSecond = chTwoActualValue;
      end
      `SMNI_SEL_DATA_CAP: begin
        twoFirst = chTwoDataValue;
        twoSecond = capValue[63:32];
      end
      `SMNI_SEL_VEL_CAP: begin
        twoFirst = chTwoVelocity;
        twoSecond = capValue[63:32];
      end
      default: begin
        twoFirst = chTwoDataValue;
        twoSecond = chTwoActualValue;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status words and word read port.
  reg [15:0] statusOne_next;
  reg [15:0] statusTwo_next;
  always @* begin
    statusOne_next = 16'h0000;
    statusOne_next[`SMNI_BIT_ACK] = ack_reg;
    statusOne_next[`SMNI_BIT_HEARTBEAT] = beat;
    statusOne_next[`SMNI_BIT_CAPTURED] = capFlag[0];
    statusOne_next[`SMNI_BIT_INPUT_STATE] = inState[0];
    statusOne_next[`SMNI_BIT_MEM_ERROR] = memoryError;
    statusOne_next[10:5] = chOneErrorBits[7:2];
    statusOne_next[`SMNI_BIT_CMD_ERROR] = cmdErrOne_reg;
    statusOne_next[3:2] = chOneErrorBits[1:0];
    statusTwo_next = 16'h0000;
    statusTwo_next[`SMNI_BIT_CAPTURED] = capFlag[1];
    statusTwo_next[`SMNI_BIT_INPUT_STATE] = inState[1];
    statusTwo_next[10:5] = chTwoErrorBits[7:2];
    statusTwo_next[`SMNI_BIT_CMD_ERROR] = cmdErrTwo_reg;
    statusTwo_next[3:2] = chTwoErrorBits[1:0];
  end

  // Word order: unswapped puts the low half first; swap reverses the pair.
  function [15:0] pick;
    input [31:0] value;
    input upperWord;
    input swap;
    begin
      pick = (upperWord ^ swap) ? value[31:16] : value[15:0];
    end
  endfunction

  reg [15:0] wordData_next;
  always @* begin
    case (wordAddr)
      4'h0: wordData_next = statusOne_next;
      4'h1: wordData_next = statusTwo_next;
      4'h2: wordData_next = pick(oneFirst, 1'b0, swapWords[0]);
      4'h3: wordData_next = pick(oneFirst, 1'b1, swapWords[0]);
      4'h4: wordData_next = pick(oneSecond, 1'b0, swapWords[0]);
      4'h5: wordData_next = pick(oneSecond, 1'b1, swapWords[0]);
      4'h6: wordData_next = pick(twoFirst, 1'b0, swapWords[1]);
      4'h7: wordData_next = pick(twoFirst, 1'b1, swapWords[1]);
      4'h8: wordData_next = pick(twoSecond, 1'b0, swapWords[1]);
      4'h9: wordData_next = pick(twoSecond, 1'b1, swapWords[1]);
      default: wordData_next = 16'h0000;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      wordData <= 16'h0000;
      chOneStatus_reg <= 16'h0000;
      chTwoStatus_reg <= 16'h0000;
    end else begin
      wordData <= wordData_next;
      chOneStatus_reg <= statusOne_next;
      chTwoStatus_reg <= statusTwo_next;
    end
  end
endmodule
`default_nettype wire

// ### inc/smni_consts.vh
// Constants for the network input status map of the two-channel encoder module.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef SMNI_CONSTS_VH
`define SMNI_CONSTS_VH
`define SMNI_WORD_CH1_STATUS 4'h0
`define SMNI_WORD_CH2_STATUS 4'h1
`define SMNI_WORD_CH1_VAL1 4'h2
`define SMNI_WORD_CH1_VAL2 4'h4
`define SMNI_WORD_CH2_VAL1 4'h6
`define SMNI_WORD_CH2_VAL2 4'h8
`define SMNI_WORD_COUNT 4'hA
`define SMNI_BIT_ACK 15
`define SMNI_BIT_HEARTBEAT 14
`define SMNI_BIT_CAPTURED 13
`define SMNI_BIT_INPUT_STATE 12
`define SMNI_BIT_MEM_ERROR 11
`define SMNI_BIT_CMD_ERROR 4
`define SMNI_CMD_TRANSMIT 15
`define SMNI_FUNC_CAP_RISE 4'h4
`define SMNI_FUNC_CAP_FALL 4'h5
`define SMNI_FUNC_CAP_BOTH 4'h6
`define SMNI_SEL_DATA_CAP 4'h3
`define SMNI_SEL_VEL_CAP 4'h4
`define SMNI_HEARTBEAT_MS 500
`define SMNI_CLK_KHZ 200000
`define SMNI_HEARTBEAT_CYCLES (`SMNI_HEARTBEAT_MS * `SMNI_CLK_KHZ)
`endif

// ### rtl/smni_heartbeat.v
// Free-running heartbeat that toggles its output once per half period.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "smni_consts.vh"
module smni_heartbeat #(
  parameter [31:0] HALF_PERIOD = `SMNI_HEARTBEAT_CYCLES
) (
  input wire clk,
  input wire srst,
  output reg beat
);
  reg [31:0] countReg;
  always @(posedge clk) begin
    if (srst) begin
      countReg <= 32'h0;
      beat <= 1'b0;
    end else if (countReg == HALF_PERIOD - 32'h1) begin
      countReg <= 32'h0;
      beat <= ~beat;
    end else begin
      countReg <= countReg + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ### rtl/smni_capture_channel.v
// One channel's discrete-input capture with value-captured flag and lockout.
// Assumes the input pin is already synchronised and the clear is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
`include "smni_consts.vh"
module smni_capture_channel (
  input wire clk,
  input wire srst,
  input wire inputSync,
  input wire [3:0] inputFunction,
  input wire [31:0] dataValue,
  input wire clearCaptured,
  output reg capturedFlag,
  output reg [31:0] capturedValue,
  output reg inputState
);
  reg inputPrev_reg;
  wire rise = inputSync & ~inputPrev_reg;
  wire fall = ~inputSync & inputPrev_reg;
  reg trigger;
  always @* begin
    case (inputFunction)
      `SMNI_FUNC_CAP_RISE: trigger = rise;
      `SMNI_FUNC_CAP_FALL: trigger = fall;
      `SMNI_FUNC_CAP_BOTH: trigger = rise | fall;
      default: trigger = 1'b0;
    endcase
  end
  // Lockout: a set flag blocks new captures; a capture arriving on the clear wins.
  wire doCapture = trigger & (~capturedFlag | clearCaptured);
  always @(posedge clk) begin
    if (srst) begin
      inputPrev_reg <= 1'b0;
      capturedFlag <= 1'b0;
      capturedValue <= 32'h0;
      inputState <= 1'b0;
    end else begin
      inputPrev_reg <= inputSync;
      inputState <= inputSync;
      if (doCapture) begin
        capturedFlag <= 1'b1;
        capturedValue <= dataValue;
      end else if (clearCaptured) begin
        capturedFlag <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/smni_input_status_assertions.sv
// Checker for the input status map, bound to its top module.
// Assumes a shortened heartbeat passed down by the bind.
`timescale 1ns/10ps
`default_nettype none
module smni_input_status_assertions #(
  parameter [31:0] HEARTBEAT_CYCLES = 32'd8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] commandWord,
  input wire logic [15:0] reservedMask,
  input wire logic [1:0] inputPin,
  input wire logic [3:0] wordAddr,
  input wire logic [15:0] wordData,
  input wire logic programStrobe,
  input wire logic [15:0] chOneStatus_reg,
  input wire logic [15:0] chTwoStatus_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic [31:0] beatCount;
  logic beatPrev, beatSeen;
  // Counts cycles since the last heartbeat change.
  always @(posedge clk) begin
    beatPrev <= chOneStatus_reg[14];
    if (srst) begin
      beatCount <= 32'h0;
      beatSeen <= 1'b0;
    end else if (chOneStatus_reg[14] != beatPrev) begin
      beatCount <= 32'h0;
      beatSeen <= 1'b1;
    end else begin
      beatCount <= beatCount + 32'h1;
    end
  end
  property p_zero;
    {chTwoStatus_reg[15:14], chTwoStatus_reg[11], chTwoStatus_reg[1:0], chOneStatus_reg[1:0]} == 7'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero bits");
  property p_ack_set;
    $rose(commandWord[15]) |-> ##[1:3] chOneStatus_reg[15];
  endproperty
  a_ack_set: assert property (p_ack_set) else $error("no ack");
  property p_ack_hold;
    chOneStatus_reg[15] && commandWord[15] && $past(commandWord[15]) |=> chOneStatus_reg[15];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack lost");
  property p_ack_drop;
    !commandWord[15] [*4] |-> !chOneStatus_reg[15];
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack stuck");
  property p_clear_one;
    !$past(srst) && $fell(chOneStatus_reg[13]) |-> $past(commandWord[15], 3) || $past(commandWord[15], 2);
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("flag one fell");
  property p_clear_two;
    !$past(srst) && $fell(chTwoStatus_reg[13]) |-> $past(commandWord[15], 3) || $past(commandWord[15], 2);
  endproperty
  a_clear_two: assert property (p_clear_two) else $error("flag two fell");
  property p_input_state;
    $stable(inputPin) [*6] |-> {chTwoStatus_reg[12], chOneStatus_reg[12]} == inputPin;
  endproperty
  a_input_state: assert property (p_input_state) else $error("input state");
  property p_unmapped;
    wordAddr > 4'h9 |=> wordData == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped word");
  property p_no_cmd;
    $rose(commandWord[15]) && commandWord[14:0] == 15'h0 |=> !programStrobe [*2];
  endproperty
  a_no_cmd: assert property (p_no_cmd) else $error("strobe");
  property p_cmd_err;
    $rose(commandWord[15]) && (commandWord & reservedMask) != 16'h0 |-> ##[1:4] (chOneStatus_reg[4] && chTwoStatus_reg[4]);
  endproperty
  a_cmd_err: assert property (p_cmd_err) else $error("cmd error");
  property p_beat;
    beatSeen |-> ((chOneStatus_reg[14] != beatPrev) == (beatCount == HEARTBEAT_CYCLES - 1));
  endproperty
  a_beat: assert property (p_beat) else $error("heartbeat");
endmodule
bind smni_input_status smni_input_status_assertions #(.HEARTBEAT_CYCLES(HEARTBEAT_CYCLES)) chk (
  .clk(clk), .srst(srst), .commandWord(commandWord), .reservedMask(reservedMask),
  .inputPin(inputPin), .wordAddr(wordAddr), .wordData(wordData),
  .programStrobe(programStrobe), .chOneStatus_reg(chOneStatus_reg),
  .chTwoStatus_reg(chTwoStatus_reg));
`default_nettype wire

// ### tb/smni_host_model.sv
// Host model writing output word 0 of the status map.
// Assumes go pulses one cycle and ack is status bit 15.
`timescale 1ns/10ps
`default_nettype none
module smni_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [14:0] cmd,
  input wire logic [1:0] gap,
  input wire logic ack,
  output logic [15:0] commandWord,
  output logic busy
);
  initial begin
    commandWord = 16'h0000;
    busy = 1'b0;
  end
  always begin
    @(posedge clk);
    if (go) begin
      busy <= 1'b1;
      commandWord <= 16'h0000;
      repeat (gap + 1) @(posedge clk);
      commandWord <= {1'b1, cmd};
      while (!ack) @(posedge clk);
      commandWord <= 16'h0000;
      while (ack) @(posedge clk);
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb/smni_input_status_test.sv
// Bench for the input status map with a host model.
// Assumes a heartbeat half period of 8 cycles.
`timescale 1ns/10ps
`default_nettype none
module smni_input_status_test;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg [15:0] rsv;
  reg [1:0] pin, swp, gap;
  reg [3:0] fn1, fn2, sel1, sel2, addr;
  reg [7:0] err1, err2;
  reg [31:0] d1, d2, a1, a2, v1, v2, cap1, rise1, rnd;
  reg memErr, go;
  reg [14:0] cmd;
  wire [15:0] cw, wd, st1, st2;
  wire strobe, busy;
  integer fails, checkCount, strobes, f, s, k;
  always #2.5 clk = ~clk;
  smni_input_status #(.HEARTBEAT_CYCLES(32'd8)) uut (.clk(clk), .srst(srst),
    .commandWord(cw), .reservedMask(rsv), .inputPin(pin), .chOneInputFunction(fn1),
    .chTwoInputFunction(fn2), .chOneValueSelect(sel1), .chTwoValueSelect(sel2),
    .swapWords(swp), .memoryError(memErr), .chOneErrorBits(err1), .chTwoErrorBits(err2),
    .chOneDataValue(d1), .chTwoDataValue(d2), .chOneActualValue(a1),
    .chTwoActualValue(a2), .chOneVelocity(v1), .chTwoVelocity(v2), .wordAddr(addr),
    .wordData(wd), .programStrobe(strobe), .chOneStatus_reg(st1), .chTwoStatus_reg(st2));
  smni_host_model hm (.clk(clk), .go(go), .cmd(cmd), .gap(gap), .ack(st1[15]),
    .commandWord(cw), .busy(busy));
  always @(posedge clk) if (strobe === 1'b1) strobes <= strobes + 1;
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [15:0] word(input [2:0] i);
    reg [31:0] v;
    begin
      case (i[2:1])
        2'd0: v = (sel1 == 2 || sel1 == 4) ? v1 : d1;
        2'd1: v = (sel1 == 0 || sel1 == 2) ? a1 : (sel1 == 1) ? v1 : cap1;
        2'd2: v = (sel2 == 2 || sel2 == 4) ? v2 : d2;
        default: v = (sel2 == 0 || sel2 == 2) ? a2 : (sel2 == 1) ? v2 : ~cap1;
      endcase
      word = (i[0] ^ swp[i[2]]) ? v[31:16] : v[15:0];
    end
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    checkCount = checkCount + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task rd(input [3:0] a, input [15:0] exp);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 check({16'h0, wd}, {16'h0, exp});
  endtask
  task pins(input [1:0] p);
    @(posedge clk);
    rnd = lfsr(rnd);
    {pin, d1, d2} <= {p, rnd, ~rnd};
    repeat (8) @(posedge clk);
  endtask
  task send(input [14:0] c);
    integer n;
    @(posedge clk);
    rnd = lfsr(rnd);
    {cmd, gap, go} <= {c, rnd[1:0], 1'b1};
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (n = 0; n < 200 && busy === 1'b1; n = n + 1) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task finish_test;
    $display("checks %0d fails %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fails = fails + 1;
    finish_test;
  end
  initial begin
    {fails, checkCount, strobes} = 96'h0;
    rnd = 32'hE9189E43;
    {pin, fn1, fn2, sel1, sel2, swp, memErr, err1, err2, rsv} <= 53'h0;
    {d1, d2, a1, a2, v1, v2, addr, go, cmd, gap} <= 214'h0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (f = 4; f < 7; f = f + 1) begin
      @(posedge clk);
      {fn1, fn2, sel1, sel2, swp} <= {f[3:0], f[3:0], 8'h33, 2'b00};
      pins(2'b11);
      rise1 = d1;
      pins(2'b00);
      cap1 = (f == 5) ? d1 : rise1;
      pins(2'b11);
      check(32'(st1[13:12]), 32'h3);
      pins(2'b00);
      check(32'({st2[13:12], st1[13:12]}), 32'hA);
      for (k = 0; k < 8; k = k + 1) rd(k[3:0] + 4'h2, word(k[2:0]));
      send(15'h0000);
      check(32'({st2[13], st1[13]}), 32'h0);
      check(strobes, 0);
      $display("capture test %0d done", f);
    end
    for (s = 0; s < 5; s = s + 1) begin
      @(posedge clk);
      rnd = lfsr(rnd);
      {sel1, sel2, swp, a1, v1} <= {s[3:0], s[3:0], rnd[1:0], rnd, ~rnd};
      {a2, v2} <= {rnd ^ 32'h0F0F0F0F, rnd + 32'h1};
      @(posedge clk);
      for (k = 0; k < 8; k = k + 1) rd(k[3:0] + 4'h2, word(k[2:0]));
    end
    for (k = 10; k < 16; k = k + 1) rd(k[3:0], 16'h0000);
    $display("select test done");
    @(posedge clk);
    rsv <= 16'h4000;
    send(15'h4000);
    check(32'({st2[4], st1[4]}), 32'h3);
    send(15'h0005);
    check(32'({st2[4], st1[4]}), 32'h0);
    check(strobes, 1);
    $display("command test done");
    @(posedge clk);
    rnd = lfsr(rnd);
    {memErr, err1, err2} <= {rnd[16], rnd[15:8], rnd[7:0]};
    repeat (3) @(posedge clk);
    #1 check(32'({st1[11:5], st1[3:2]}), {23'h0, memErr, err1});
    rd(4'h1, {5'h00, err2[7:2], 1'b0, err2[1:0], 2'b00});
    $display("error bit test done");
    finish_test;
  end
endmodule
`default_nettype wire
